// *** core/rmat_engine.v ***
/*
  Mode controller and auto-acknowledge transmit engine of a packet radio.
  Assumes host bytes arrive already deserialised from the serial port on clk,
  and that the modem reports ack, receive and on-air-done as clk-domain pulses.
*/
// Functional notes
// [RULE1] RX or TX mode from power, role, activate
// [RULE2] Activate falling mid-packet finishes the packet
// [RULE3] Transmitter, activate high, empty FIFO: idle_high
// [RULE4] Power off gives power-down; else idle_low
// [RULE5] State kept and port usable when idle
// [RULE6] Activate low in idle_high: idle_low at once
// [RULE7] Host holds activate high ten microseconds
// [RULE8] Payload length is bytes written per transfer
// [RULE9] Three-entry TX and RX FIFOs, six pipes
// [RULE10] FIFOs accessible in every mode
// [RULE11] Modem frames packet; interrupt on completion
// [RULE12] Interrupt once valid packet received
// [RULE13] Transmit start powers radio and clock
// [RULE14] Six pipes; pipe zero full address
// [RULE15] Acknowledge uses receiving pipe address
// [RULE16] Host sets pipe zero to destination address
// [RULE17] Ack in window: sent flag, drop payload
// [RULE18] No ack: resend; past limit flag, keep
// [RULE19] Interrupt low while flags; host write clears
// [RULE20] Retry-limit flag blocks further sending
// [RULE21] Lost tally per limit event; retry tally
// [RULE22] After packet: idle_low, next, or idle_high
// [RULE23] Channel write clears lost tally
// [RULE24] Retry sequence stops only by power or limit
// [RULE25] Retry tally cleared per new payload
`timescale 1ns/10ps
`default_nettype none
`include "rmat_map.vh"

module rmat_engine #(
  parameter ACK_CYCLES = `RMAT_ACK_WINDOW_US * `RMAT_CLK_MHZ,
  parameter LEN_W = `RMAT_LEN_W
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Host pins
  input wire radio_activate_pin,
  input wire spi_select_low,
  output wire irq_low,
  // Configuration bits
  input wire power_on_bit,
  input wire receive_role_bit,
  input wire pipe_zero_autoack,
  input wire retransmit_enable,
  input wire [3:0] retry_limit,
  input wire rate_2m,
  input wire channel_write,
  input wire [`RMAT_ADDR_W-1:0] pipe_zero_listen_address,
  input wire [`RMAT_SHARED_W-1:0] pipe_shared_upper,
  input wire [39:0] pipe_low_bytes,
  // Status clear pulses
  input wire clear_sent,
  input wire clear_retry_limit,
  input wire clear_receive_ready,
  // Host byte path into TX FIFO
  input wire send_payload_byte,
  input wire [7:0] send_payload_data,
  output wire send_payload_ready,
  // Host read of RX FIFO
  input wire recv_pop,
  input wire [LEN_W-1:0] recv_index,
  output wire [7:0] recv_data,
  output wire [LEN_W-1:0] recv_len,
  output wire recv_valid,
  output reg [2:0] recv_pipe,
  // Modem side
  output reg radio_power,
  output reg sync_clock_run,
  output reg modem_tx_start,
  output reg [`RMAT_ADDR_W-1:0] modem_address,
  output reg modem_rate_2m,
  output wire [7:0] modem_tx_data,
  input wire [LEN_W-1:0] modem_tx_index,
  output wire [LEN_W-1:0] modem_tx_len,
  input wire modem_tx_done,
  input wire modem_ack_ok,
  input wire modem_rx_byte,
  input wire [7:0] modem_rx_data,
  input wire modem_rx_end,
  input wire [2:0] modem_rx_pipe,
  // Status
  output reg [5:0] mode,
  output reg sent_flag,
  output reg retry_limit_flag,
  output reg receive_ready_flag,
  output reg [3:0] retry_tally,
  output reg [3:0] lost_packet_tally
);
  localparam [5:0] S_PDOWN = `RMAT_MODE_PDOWN;
  localparam [5:0] S_IDLE_LOW = `RMAT_MODE_IDLE_LOW;
  localparam [5:0] S_IDLE_HIGH = `RMAT_MODE_IDLE_HIGH;
  localparam [5:0] S_TX = `RMAT_MODE_TX;
  localparam [5:0] S_ACK = `RMAT_MODE_ACK_WAIT;
  localparam [5:0] S_RX = `RMAT_MODE_RX;
  localparam ACT_MIN_CYCLES = `RMAT_ACTIVATE_MIN_US * `RMAT_CLK_MHZ;

  // Two-stage synchronisers for pins
  reg act_s1;
  reg act;
  reg sel_s1;
  reg sel;
  always @(posedge clk) begin
    if (!rst_n) begin
      act_s1 <= 1'b0;
      act <= 1'b0;
    end else begin
      act_s1 <= radio_activate_pin;
      act <= act_s1;
    end
  end

  // Select resets to its idle level so no false close follows reset
  always @(posedge clk) begin
    if (!rst_n) begin
      sel_s1 <= 1'b1;
      sel <= 1'b1;
    end else begin
      sel_s1 <= spi_select_low;
      sel <= sel_s1;
    end
  end

  // Select rising closes one payload transfer
  reg sel_d;
  always @(posedge clk) begin
    if (!rst_n) begin
      sel_d <= 1'b1;
    end else begin
      sel_d <= sel;
    end
  end
  wire sel_rise = sel && !sel_d;

  // Transmit FIFO, written from the host at any mode
  wire tx_valid;
  reg tx_pop;
  wire [1:0] tx_count;
  rmat_fifo #(.LEN_W(LEN_W)) u_txq (
    .clk(clk),
    .rst_n(rst_n),
    .wr_byte(send_payload_byte && !sel), // see [RULE10]
    .wr_data(send_payload_data),
    .wr_close(sel_rise), // see [RULE8]
    .wr_ready(send_payload_ready),
    .rd_pop(tx_pop), // see [RULE17]
    .rd_index(modem_tx_index),
    .rd_data(modem_tx_data),
    .rd_len(modem_tx_len),
    .rd_valid(tx_valid),
    .count(tx_count),
    .flush(1'b0)
  );

  // Receive FIFO, shared by all six pipes
  reg rx_close;
  rmat_fifo #(.LEN_W(LEN_W)) u_rxq (
    .clk(clk),
    .rst_n(rst_n),
    .wr_byte(modem_rx_byte && mode == S_RX),
    .wr_data(modem_rx_data),
    .wr_close(rx_close), // see [RULE9]
    .wr_ready(),
    .rd_pop(recv_pop), // see [RULE10]
    .rd_index(recv_index),
    .rd_data(recv_data),
    .rd_len(recv_len),
    .rd_valid(recv_valid),
    .count(),
    .flush(1'b0)
  );

  // Address of a pipe: pipe 0 own, others share upper bits
  function [`RMAT_ADDR_W-1:0] pipe_addr;
    input [2:0] p;
    begin
      if (p == 3'h0) begin
        pipe_addr = pipe_zero_listen_address;
      end else begin
        pipe_addr = {pipe_shared_upper, pipe_low_bytes[(p-1)*8 +: 8]}; // see [RULE14]
      end
    end
  endfunction

  // Activate must stay high a minimum before a send starts from idle_low, power-down or receive
  reg [10:0] act_cnt;
  always @(posedge clk) begin
    if (!rst_n || !act) begin
      act_cnt <= 11'h000;
    end else if (act_cnt != ACT_MIN_CYCLES[10:0]) begin
      act_cnt <= act_cnt + 11'h001;
    end
  end
  wire act_ok = (act_cnt == ACT_MIN_CYCLES[10:0]); // see [RULE7]

  // Acknowledge window timer
  reg [31:0] win_cnt;
  reg [5:0] next_mode;
  // A pop still in flight leaves tx_valid stale for one cycle
  wire can_send = tx_valid && !tx_pop && !retry_limit_flag; // see [RULE20]
  wire win_out = (win_cnt == ACK_CYCLES - 1);

  always @* begin
    next_mode = mode;
    case (mode)
      S_PDOWN, S_IDLE_LOW, S_IDLE_HIGH, S_RX: begin
        if (!act) begin
          next_mode = S_IDLE_LOW; // see [RULE4] [RULE6]
        end else if (receive_role_bit) begin
          next_mode = S_RX; // see [RULE1]
        end else if (can_send && (act_ok || mode == S_IDLE_HIGH)) begin
          next_mode = S_TX; // see [RULE1]
        end else if (!can_send) begin
          next_mode = S_IDLE_HIGH; // see [RULE3]
        end
      end
      S_TX: begin
        // Packet on air finishes even if activate falls
        if (modem_tx_done) begin // see [RULE2]
          if (pipe_zero_autoack) begin
            next_mode = S_ACK; // see [RULE17]
          end else if (!act) begin
            next_mode = S_IDLE_LOW; // see [RULE22]
          end else begin
            next_mode = S_IDLE_HIGH;
          end
        end
      end
      S_ACK: begin
        if (modem_ack_ok || (win_out && (!retransmit_enable || retry_tally >= retry_limit))) begin
          next_mode = act ? S_IDLE_HIGH : S_IDLE_LOW; // see [RULE22]
        end else if (win_out) begin
          next_mode = S_TX; // see [RULE18] [RULE24]
        end
      end
      default: next_mode = S_IDLE_LOW;
    endcase
    if (!power_on_bit) begin
      next_mode = S_PDOWN; // see [RULE4] [RULE24]
    end
  end

  // Status registers hold through idle and power-down
  wire ack_hit = (mode == S_ACK) && modem_ack_ok;
  wire give_up = (mode == S_ACK) && !modem_ack_ok && win_out &&
    (!retransmit_enable || retry_tally >= retry_limit);
  wire noack_done = (mode == S_TX) && modem_tx_done && !pipe_zero_autoack;
  wire rx_good = (mode == S_RX) && modem_rx_end && modem_rx_pipe < `RMAT_PIPES;
  wire tx_entry = (next_mode == S_TX) && (mode != S_TX);

  always @(posedge clk) begin
    if (!rst_n) begin
      mode <= S_PDOWN;
    end else begin
      mode <= next_mode; // see [RULE5]
    end
  end

  // Window restarts on every entry to ack wait
  always @(posedge clk) begin
    if (!rst_n) begin
      win_cnt <= 32'h00000000;
    end else begin
      win_cnt <= (mode == S_ACK && !win_out) ? win_cnt + 32'h00000001 : 32'h00000000;
    end
  end

  // FIFO strobes and receive pipe number
  always @(posedge clk) begin
    if (!rst_n) begin
      tx_pop <= 1'b0;
      rx_close <= 1'b0;
      recv_pipe <= 3'h0;
    end else begin
      tx_pop <= ack_hit || noack_done; // see [RULE17]
      rx_close <= rx_good;
      if (rx_good) begin
        recv_pipe <= modem_rx_pipe;
      end
    end
  end

  // Radio controls toward the modem
  always @(posedge clk) begin
    if (!rst_n) begin
      radio_power <= 1'b0;
      sync_clock_run <= 1'b0;
      modem_tx_start <= 1'b0;
      modem_address <= {`RMAT_ADDR_W{1'b0}};
      modem_rate_2m <= 1'b0;
    end else begin
      modem_tx_start <= tx_entry; // see [RULE11]
      radio_power <= (next_mode == S_TX) || (next_mode == S_ACK) || (next_mode == S_RX); // see [RULE13]
      sync_clock_run <= (next_mode != S_PDOWN) && (next_mode != S_IDLE_LOW); // see [RULE13]
      modem_rate_2m <= rate_2m; // see [RULE13]
      // Pipe zero listens for the acks of our own sends
      if (tx_entry) begin
        modem_address <= pipe_zero_listen_address;
      end else if (rx_good) begin
        modem_address <= pipe_addr(modem_rx_pipe); // see [RULE15]
      end
    end
  end

  // Retry and lost-packet tallies
  always @(posedge clk) begin
    if (!rst_n) begin
      retry_tally <= 4'h0;
      lost_packet_tally <= `RMAT_LOST_RST;
    end else begin
      if (tx_entry && mode != S_ACK) begin
        retry_tally <= 4'h0; // see [RULE25]
      end else if (mode == S_ACK && next_mode == S_TX) begin
        retry_tally <= retry_tally + 4'h1; // see [RULE21]
      end
      // Saturates so a long outage never wraps to a small count
      if (channel_write) begin
        lost_packet_tally <= 4'h0; // see [RULE23]
      end else if (give_up && lost_packet_tally != 4'hF) begin
        lost_packet_tally <= lost_packet_tally + 4'h1; // see [RULE21]
      end
    end
  end

  // Hardware set wins over host clear
  always @(posedge clk) begin
    if (!rst_n) begin
      sent_flag <= 1'b0;
      retry_limit_flag <= 1'b0;
      receive_ready_flag <= 1'b0;
    end else begin
      sent_flag <= (ack_hit || noack_done) || (sent_flag && !clear_sent); // see [RULE17] [RULE11]
      retry_limit_flag <= give_up || (retry_limit_flag && !clear_retry_limit); // see [RULE18]
      receive_ready_flag <= rx_good || (receive_ready_flag && !clear_receive_ready); // see [RULE12]
    end
  end

  assign irq_low = !(sent_flag || retry_limit_flag || receive_ready_flag); // see [RULE19]
endmodule // rmat_engine

`default_nettype wire

// *** core/rmat_map.vh ***
/*
  Constants for the mode controller and auto-acknowledge transmit engine.
  Assumes inclusion by core design files only.
*/
`ifndef RMAT_MAP_VH
`define RMAT_MAP_VH

// Mode codes, one-hot
`define RMAT_MODE_PDOWN 6'h01
`define RMAT_MODE_IDLE_LOW 6'h02
`define RMAT_MODE_IDLE_HIGH 6'h04
`define RMAT_MODE_TX 6'h08
`define RMAT_MODE_ACK_WAIT 6'h10
`define RMAT_MODE_RX 6'h20

// FIFO geometry
`define RMAT_FIFO_DEPTH 3
`define RMAT_BYTE_W 8
`define RMAT_LEN_W 6
`define RMAT_MAX_BYTES 32

// Pipe addressing
`define RMAT_PIPES 6
`define RMAT_ADDR_W 40
`define RMAT_SHARED_W 32

// Timing
`define RMAT_CLK_MHZ 125
`define RMAT_ACK_WINDOW_US 250
`define RMAT_ACTIVATE_MIN_US 10
`define RMAT_SYNC_MHZ 16

// Reset values
`define RMAT_RETRY_LIMIT_RST 4'h3
`define RMAT_LOST_RST 4'h0

`endif

// *** core/rmat_fifo.v ***
/*
  Three-entry byte-packet FIFO; each entry holds a payload and its length.
  Assumes writer and reader run on the same clock as the core.
*/
`timescale 1ns/10ps
`default_nettype none
`include "rmat_map.vh"

module rmat_fifo #(
  parameter DEPTH = `RMAT_FIFO_DEPTH,
  parameter BYTES = `RMAT_MAX_BYTES,
  parameter LEN_W = `RMAT_LEN_W
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Byte write side
  input wire wr_byte,
  input wire [7:0] wr_data,
  input wire wr_close,
  output wire wr_ready,
  // Packet read side
  input wire rd_pop,
  input wire [LEN_W-1:0] rd_index,
  output reg [7:0] rd_data,
  output wire [LEN_W-1:0] rd_len,
  output wire rd_valid,
  output wire [1:0] count,
  input wire flush
);
  reg [7:0] mem [0:DEPTH*BYTES-1];
  reg [LEN_W-1:0] len [0:DEPTH-1];
  reg [1:0] wp;
  reg [1:0] rp;
  reg [1:0] cnt;
  reg [LEN_W-1:0] fill;
  integer i;

  function [1:0] bump;
    input [1:0] p;
    begin
      bump = (p == DEPTH - 1) ? 2'h0 : p + 2'h1;
    end
  endfunction

  assign wr_ready = (cnt != DEPTH);
  assign rd_valid = (cnt != 2'h0);
  assign rd_len = len[rp];
  assign count = cnt;

  always @(posedge clk) begin
    rd_data <= mem[rp*BYTES + rd_index];
  end

  always @(posedge clk) begin
    if (!rst_n || flush) begin
      wp <= 2'h0;
      rp <= 2'h0;
      cnt <= 2'h0;
      fill <= {LEN_W{1'b0}};
      for (i = 0; i < DEPTH; i = i + 1) begin
        len[i] <= {LEN_W{1'b0}};
      end
    end else begin
      // Length comes from the bytes actually written
      if (wr_byte && wr_ready && fill < BYTES) begin
        mem[wp*BYTES + fill] <= wr_data;
        fill <= fill + 1'b1;
      end
      if (wr_close && wr_ready && fill != 0) begin
        len[wp] <= fill;
        wp <= bump(wp);
        fill <= {LEN_W{1'b0}};
      end
      if (rd_pop && rd_valid) begin
        rp <= bump(rp);
      end
      case ({wr_close && wr_ready && fill != 0, rd_pop && rd_valid})
        2'b10: cnt <= cnt + 2'h1;
        2'b01: cnt <= cnt - 2'h1;
        default: cnt <= cnt;
      endcase
    end
  end
endmodule // rmat_fifo

`default_nettype wire

// *** test/rmat_chk_sva.sv ***
/* Assertion checker for rmat_engine.
   Assumes binding to the engine top, single clk domain. */
`timescale 1ns/10ps
`default_nettype none
module rmat_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Inputs watched
  input wire logic radio_activate_pin,
  input wire logic power_on_bit,
  input wire logic channel_write,
  input wire logic modem_ack_ok,
  input wire logic modem_tx_done,
  // Outputs watched
  input wire logic irq_low,
  input wire logic modem_tx_start,
  input wire logic [5:0] mode,
  input wire logic sent_flag,
  input wire logic retry_limit_flag,
  input wire logic receive_ready_flag,
  input wire logic [3:0] lost_packet_tally
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_pdown; !power_on_bit |=> mode == 6'h01; endproperty
  a_pdown: assert property (p_pdown) else $error("not power-down");
  property p_irq; irq_low == !(sent_flag || retry_limit_flag || receive_ready_flag); endproperty
  a_irq: assert property (p_irq) else $error("irq level wrong");
  property p_sent; mode == 6'h10 && modem_ack_ok && power_on_bit |=> sent_flag; endproperty
  a_sent: assert property (p_sent) else $error("ack not flagged");
  // Start pulse is launched on the same edge as the mode change
  property p_start; $changed(mode) && mode == 6'h08 |-> modem_tx_start; endproperty
  a_start: assert property (p_start) else $error("no tx start");
  property p_block; retry_limit_flag |-> !modem_tx_start; endproperty
  a_block: assert property (p_block) else $error("sent while blocked");
  property p_lost;
    $rose(retry_limit_flag) && !$past(channel_write) |->
      lost_packet_tally == $past(lost_packet_tally) + 4'h1 || lost_packet_tally == 4'hF;
  endproperty
  a_lost: assert property (p_lost) else $error("lost tally off");
  property p_chan; channel_write && mode != 6'h10 |=> lost_packet_tally == 4'h0; endproperty
  a_chan: assert property (p_chan) else $error("tally not cleared");
  // Three cycles cover the activate synchroniser
  property p_drop;
    (mode == 6'h04 && !radio_activate_pin && power_on_bit) [*3] |-> ##[1:2] mode == 6'h02;
  endproperty
  a_drop: assert property (p_drop) else $error("idle_high kept");
  property p_hold;
    mode == 6'h08 && !modem_tx_done && power_on_bit |=> mode == 6'h08;
  endproperty
  a_hold: assert property (p_hold) else $error("tx left early");
  c_sent: cover property ($rose(sent_flag));
  c_limit: cover property ($rose(retry_limit_flag));
  c_high: cover property (mode == 6'h04);
endmodule // rmat_chk
`default_nettype wire

// *** test/rmat_modem_model.sv ***
/* Modem stand-in: ends each frame, then answers with an optional ack.
   Assumes engine pulses modem_tx_start for one clk. */
`timescale 1ns/10ps
`default_nettype none
module rmat_modem_model (
  // Clock
  input wire logic clk,
  // Engine side
  input wire logic modem_tx_start,
  output logic modem_tx_done = 1'b0,
  output logic modem_ack_ok = 1'b0,
  // Scenario control
  input wire logic ack_en
);
  int cnt = 0;
  // Ack lands well inside a 20-cycle window
  always @(posedge clk) begin
    modem_tx_done <= 1'b0;
    modem_ack_ok <= 1'b0;
    if (modem_tx_start) cnt <= 1;
    else if (cnt != 0) cnt <= cnt + 1;
    if (cnt == 6) modem_tx_done <= 1'b1;
    if (cnt == 9) begin
      modem_ack_ok <= ack_en;
      cnt <= 0;
    end
  end
endmodule // rmat_modem_model
`default_nettype wire

// *** test/tb.sv ***
/* Self-checking bench for rmat_engine with modem model.
   Assumes short ack window parameter of 20 cycles. */
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk = 0, rst_n = 0, radio_activate_pin = 0, spi_select_low = 1;
  logic power_on_bit = 0, receive_role_bit = 0, pipe_zero_autoack = 1;
  logic retransmit_enable = 1, rate_2m = 0, channel_write = 0, ack_en = 1;
  logic clear_sent = 0, clear_retry_limit = 0, clear_receive_ready = 0;
  logic send_payload_byte = 0, recv_pop = 0, modem_rx_byte = 0, modem_rx_end = 0;
  logic [3:0] retry_limit = 4'h3;
  logic [39:0] pipe_zero_listen_address = 40'hE7E7E7E7E7;
  logic [31:0] pipe_shared_upper = 32'hC2C2C2C2;
  logic [39:0] pipe_low_bytes = 40'hC6C5C4C3C2;
  logic [7:0] send_payload_data = 8'h00, modem_rx_data = 8'h5A;
  logic [5:0] recv_index = 6'h00, modem_tx_index = 6'h00;
  logic [2:0] modem_rx_pipe = 3'h0;
  logic irq_low, send_payload_ready, recv_valid, radio_power, sync_clock_run;
  logic modem_tx_start, modem_rate_2m, modem_tx_done, modem_ack_ok;
  logic sent_flag, retry_limit_flag, receive_ready_flag;
  logic [7:0] recv_data, modem_tx_data;
  logic [5:0] recv_len, modem_tx_len, mode;
  logic [2:0] recv_pipe;
  logic [39:0] modem_address;
  logic [3:0] retry_tally, lost_packet_tally;
  int error_cnt = 0, samples_checked = 0, starts = 0;
  always #4 clk = ~clk;
  // Count of send starts, to spot stray or blocked sends
  always @(posedge clk) if (modem_tx_start) starts <= starts + 1;
  rmat_engine #(.ACK_CYCLES(20)) i_rmat_engine (.*);
  rmat_modem_model i_rmat_modem_model (.*);
  task tick(input int k);
    repeat (k) @(posedge clk);
  endtask
  task chk(input logic [39:0] s, input logic [39:0] e);
    samples_checked++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %0t saw %h want %h", $time, s, e);
    end
  endtask
  function logic cond(input int c);
    case (c)
      0: cond = mode === 6'h08;
      1: cond = sent_flag === 1'b1;
      2: cond = mode === 6'h04;
      3: cond = retry_limit_flag === 1'b1;
      default: cond = mode === 6'h20;
    endcase
  endfunction
  task wt(input int c, input int lim);
    for (int n = 0; n < lim && !cond(c); n++) tick(1);
  endtask
  task spi(input int k);
    spi_select_low <= 0;
    tick(3);
    for (int i = 0; i < k; i++) begin
      send_payload_byte <= 1;
      send_payload_data <= 8'hA0 + i[7:0];
      tick(1);
    end
    send_payload_byte <= 0;
    spi_select_low <= 1;
    tick(5);
  endtask
  task wrap_up;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Whole run needs about 2800 cycles
  initial begin
    #160000;
    error_cnt++;
    wrap_up;
  end
  initial begin
    tick(6);
    rst_n <= 1;
    tick(4);
    chk(mode, 6'h01);
    power_on_bit <= 1;
    tick(4);
    chk(mode, 6'h02);
    spi(3);
    spi(2);
    rate_2m <= 1;
    radio_activate_pin <= 1;
    wt(0, 1400);
    chk(modem_tx_len, 3);
    chk({radio_power, sync_clock_run, modem_rate_2m}, 3'h7);
    wt(1, 100);
    chk(irq_low, 0);
    wt(0, 50);
    chk(modem_tx_len, 2);
    wt(2, 200);
    chk(mode, 6'h04);
    tick(20);
    chk(mode, 6'h04);
    chk(starts, 2);
    radio_activate_pin <= 0;
    tick(5);
    chk(mode, 6'h02);
    $display("send test ended");
    clear_sent <= 1;
    ack_en <= 0;
    retry_limit <= 4'h2;
    tick(1);
    clear_sent <= 0;
    spi(1);
    radio_activate_pin <= 1;
    wt(3, 1600);
    chk(retry_tally, 2);
    chk(lost_packet_tally, 1);
    tick(30);
    chk({retry_limit_flag, irq_low}, 2'h2);
    chk(starts, 5);
    ack_en <= 1;
    clear_retry_limit <= 1;
    tick(1);
    clear_retry_limit <= 0;
    wt(0, 50);
    chk(modem_tx_len, 1);
    chk(retry_tally, 0);
    radio_activate_pin <= 0;
    wt(1, 100);
    chk(sent_flag, 1);
    tick(5);
    chk(mode, 6'h02);
    channel_write <= 1;
    tick(1);
    channel_write <= 0;
    tick(1);
    chk(lost_packet_tally, 0);
    $display("retry test ended");
    receive_role_bit <= 1;
    radio_activate_pin <= 1;
    wt(4, 20);
    chk(mode, 6'h20);
    modem_rx_pipe <= 3'h2;
    modem_rx_byte <= 1;
    tick(2);
    modem_rx_byte <= 0;
    modem_rx_end <= 1;
    tick(1);
    modem_rx_end <= 0;
    tick(2);
    chk({receive_ready_flag, recv_valid, recv_pipe, recv_len}, {2'h3, 3'h2, 6'h02});
    chk(modem_address, 40'hC2C2C2C2C3);
    chk(recv_data, 8'h5A);
    // The sent flag of the last send still holds the interrupt
    clear_sent <= 1;
    clear_receive_ready <= 1;
    recv_pop <= 1;
    tick(1);
    clear_sent <= 0;
    clear_receive_ready <= 0;
    recv_pop <= 0;
    tick(2);
    chk({irq_low, recv_valid}, 2'h2);
    power_on_bit <= 0;
    tick(2);
    chk(mode, 6'h01);
    $display("receive test ended");
    wrap_up;
  end
endmodule // tb
bind rmat_engine rmat_chk i_rmat_chk (.*);
`default_nettype wire
